// ===== hw/rsq_pkg.sv
package rsq_pkg;
	// power-up release delay, figure as printed (typical bound)
	localparam int PowerUpReleaseDelayUs = 300;
	localparam int ClkMhz = 25;
	localparam int PowerUpReleaseCycles = PowerUpReleaseDelayUs * ClkMhz;
	localparam int WdtDivide = 12;
	localparam logic [7:0] PortLatchReset = 8'hFF;
	localparam logic [15:0] ResetVector = 16'h0000;
	localparam logic [7:0] StackPtrReset = 8'h07;
	localparam int CauseWidth = 8;
	localparam int PorFlagBit = 1;
	localparam int PinFlagBit = 0;
	localparam int SoftFlagBit = 4;
	localparam logic [1:0] ClkSrcInternal = 2'h0;

	typedef enum logic [1:0] {
		RSQ_POR_HOLD = 2'b00,
		RSQ_POR_DELAY = 2'b01,
		RSQ_RUN = 2'b11,
		RSQ_WARM = 2'b10
	} rsq_state_e;
endpackage : rsq_pkg

// ===== hw/rsq_reset_sequencer.sv
// Overview of operation
// [R01] halt cpu for whole reset state
// [R02] hold special function registers in reset
// [R03] disable interrupts and timers in reset
// [R04] leave data memory untouched by reset
// [R05] reload stack pointer on every reset
// [R06] port latches all ones, open-drain
// [R07] weak pullups on during and after
// [R08] drive reset pin low for supply resets
// [R09] clear program counter, internal oscillator selected
// [R10] watchdog enabled, clocked sysclk divided by twelve
// [R11] fetch always starts at address zero
// [R12] hold while supply low, then delay
// [R13] set power-on flag after supply resets
// [R14] other resets clear power-on flag
// [R15] software checks flag; memory undefined after power-up
// [R16] power-on reset enables supply monitor
// [R17] monitor enable survives non-power-on resets
// [R18] monitor reset ends without release delay
// [R19] synchronise supply-good and pin inputs
`timescale 1ns/1ps
module rsq_reset_sequencer
	import rsq_pkg::*;
#(
	parameter int ReleaseCycles = PowerUpReleaseCycles
) (
	input wire logic clk_sys, // system clock, 25 MHz
	input wire logic rstn, // power-on reset from the pad cell, active low
	input wire logic supplyGood, // supply above supply_reset_threshold
	input wire logic resetPinIn, // level seen on the reset pin
	input wire logic softReset, // software reset request, one pulse
	input wire logic monitorEnWrite, // software write strobe for monitor enable
	input wire logic monitorEnData, // value written to monitor enable
	input wire logic monitorIsSource, // monitor selected as reset source
	output logic resetPinOut, // reset pin output level
	output logic resetPinOe, // reset pin output enable
	output logic cpuHalt, // processor halted
	output logic sfrReset, // special_function_registers forced to reset
	output logic irqTimerDisable, // interrupts and timers disabled
	output logic memWriteBlock, // data memory left untouched
	output logic [7:0] stackPointerInit, // stack pointer reload value
	output logic [7:0] portLatch, // port output latches
	output logic portOpenDrain, // ports in open-drain mode
	output logic weakPullupEn, // weak pullups enabled
	output logic [15:0] program_counter, // fetch address on release
	output logic [1:0] clockSource, // system clock source select
	output logic wdtEnable, // watchdog enable
	output logic wdtTick, // watchdog clock, sysclk over twelve
	output logic monitorEnable, // supply monitor enable
	output logic [7:0] reset_cause_register // cause flags
);
	rsq_state_e state;
	rsq_state_e next_state;
	logic supplyOk;
	logic pinOk;
	logic [12:0] delayCount;
	logic [3:0] wdtDiv;
	logic supplyCause;
	logic pinCause;
	logic softPending;
	logic pinSeen;

	////////////////////////////////////////////////////////////////
	// cause word written on every release; flags not named stay zero
	function automatic logic [CauseWidth-1:0] causeFlags(
		input logic fromSupply,
		input logic fromPin
	);
		logic [CauseWidth-1:0] flags;
		flags = 8'h00;
		if (fromSupply) begin
			flags[PorFlagBit] = 1'b1; // R13
		end else begin
			// power flag stays low, so the pin and soft flags are defined
			flags[PorFlagBit] = 1'b0; // R14
			flags[PinFlagBit] = fromPin;
			flags[SoftFlagBit] = !fromPin;
		end
		return flags;
	endfunction : causeFlags

	////////////////////////////////////////////////////////////////
	// our own low drive on the pin must not read back as a pin reset:
	// the stages fill with ones while we drive, so release is clean
	assign pinSeen = resetPinIn || resetPinOe;

	rsq_sync2 uSyncSupply ( // R19
		.clk_sys(clk_sys),
		.rstn(rstn),
		.din(supplyGood),
		.dout(supplyOk)
	);
	rsq_sync2 uSyncPin ( // R19
		.clk_sys(clk_sys),
		.rstn(rstn),
		.din(pinSeen),
		.dout(pinOk)
	);

	////////////////////////////////////////////////////////////////
	wire inReset = (state != RSQ_RUN);
	wire supplyDrop = !supplyOk && (monitorEnable && monitorIsSource);
	wire delayDone = (delayCount == 13'(ReleaseCycles - 1));
	// pin reset only leaves once the supply is good too; our own drive keeps pinOk high in a supply reset
	wire warmRelease = supplyOk && pinOk && !softPending;

	always_comb begin
		next_state = state;
		unique case (state)
			RSQ_POR_HOLD: begin
				// stay here while the supply is below threshold
				if (supplyOk) begin
					next_state = RSQ_POR_DELAY; // R12
				end
			end
			RSQ_POR_DELAY: begin
				// a dip during the delay restarts the whole power-up
				if (!supplyOk) begin
					next_state = RSQ_POR_HOLD;
				end else if (delayDone) begin
					next_state = RSQ_RUN; // R12
				end
			end
			RSQ_RUN: begin
				if (supplyDrop || !pinOk || softReset) begin
					next_state = RSQ_WARM;
				end
			end
			RSQ_WARM: begin
				// no release delay on this path
				if (warmRelease) begin
					next_state = RSQ_RUN; // R18
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) state <= RSQ_POR_HOLD;
		else state <= next_state;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) delayCount <= 13'h0000;
		else if (state == RSQ_POR_DELAY && !delayDone)
			delayCount <= delayCount + 13'h0001;
		else if (state != RSQ_POR_DELAY) delayCount <= 13'h0000;
	end

	// soft request is one cycle; hold it one extra so warm state is seen
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) softPending <= 1'b0;
		else softPending <= (state == RSQ_RUN) && softReset;
	end

	////////////////////////////////////////////////////////////////
	// cause capture at entry of a warm reset
	wire warmEntry = (state == RSQ_RUN) && (next_state == RSQ_WARM);
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			supplyCause <= 1'b1;
			pinCause <= 1'b0;
		end else if (warmEntry) begin
			supplyCause <= supplyDrop;
			pinCause <= !supplyDrop && !pinOk;
		end
	end

	wire leaving = inReset && (next_state == RSQ_RUN);
	wire [CauseWidth-1:0] next_causeReg = causeFlags(supplyCause, pinCause);

	// flags change only on the release edge, never while running
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reset_cause_register <= 8'h00;
		end else if (leaving) begin
			reset_cause_register <= next_causeReg; // R13 R14
		end
	end

	// enable is set by power-on or a software write while running, kept across other resets
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) monitorEnable <= 1'b1; // R16
		else if (monitorEnWrite && !inReset)
			monitorEnable <= monitorEnData; // R17
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			program_counter <= ResetVector;
			clockSource <= ClkSrcInternal;
			portLatch <= PortLatchReset;
		end else if (inReset) begin
			program_counter <= ResetVector; // R09 R11
			clockSource <= ClkSrcInternal; // R09
			portLatch <= PortLatchReset; // R06
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) wdtDiv <= 4'h0;
		else if (inReset || wdtDiv == 4'(WdtDivide - 1)) wdtDiv <= 4'h0;
		else wdtDiv <= wdtDiv + 4'h1; // R10
	end

	assign wdtTick = !inReset && (wdtDiv == 4'(WdtDivide - 1));
	assign wdtEnable = 1'b1; // R10
	assign cpuHalt = inReset; // R01
	assign sfrReset = inReset; // R02
	assign irqTimerDisable = inReset; // R03
	assign memWriteBlock = inReset; // R04
	assign stackPointerInit = StackPtrReset; // R05
	assign portOpenDrain = 1'b1; // R06
	assign weakPullupEn = 1'b1; // R07
	// pin driven low only for power-on and monitor resets
	assign resetPinOe = inReset && supplyCause; // R08
	assign resetPinOut = 1'b0;
endmodule : rsq_reset_sequencer

// ===== hw/rsq_sync2.sv
`timescale 1ns/1ps
module rsq_sync2 (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic din, // asynchronous level
	output logic dout // synchronised level
);
	logic stage1;
	logic stage2;

	// stage1 feeds stage2 only
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
		end else begin
			stage1 <= din;
			stage2 <= stage1;
		end
	end
	assign dout = stage2;
endmodule : rsq_sync2

// ===== test/rsq_reset_checker.sv
`timescale 1ns/1ps
module rsq_reset_checker (
	input wire logic clk_sys, rstn, softReset, cpuHalt, sfrReset,
	input wire logic irqTimerDisable, resetPinOe, resetPinOut, wdtTick,
	input wire logic monitorEnable,
	input wire logic [7:0] portLatch, reset_cause_register,
	input wire logic [15:0] program_counter,
	input wire logic [1:0] clockSource
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_soft; softReset && !cpuHalt; endsequence
	sequence s_exit; $fell(cpuHalt); endsequence
	chk_halt_soft: assert property (s_soft |=> cpuHalt)
		else $error("soft reset no halt");
	chk_soft_clear: assert property (s_soft |-> ##[2:8] s_exit ##0
		!reset_cause_register[1]) else $error("soft exit wrong");
	chk_reset_outs: assert property (cpuHalt |-> sfrReset && irqTimerDisable)
		else $error("reset outputs low");
	chk_port_ones: assert property (cpuHalt |-> portLatch == 8'hFF)
		else $error("latches not ones");
	chk_exit_vals: assert property (s_exit |-> program_counter == 16'h0000
		&& clockSource == 2'h0) else $error("exit state wrong");
	chk_pin_drive: assert property (resetPinOe |-> cpuHalt && !resetPinOut)
		else $error("pin driven outside reset");
	chk_por_flag: assert property ($fell(resetPinOe) |-> reset_cause_register[1])
		else $error("power flag clear");
	chk_wdt_gap: assert property (wdtTick |=> !wdtTick [*8])
		else $error("watchdog tick early");
	chk_mon_on: assert property ($rose(rstn) |-> monitorEnable)
		else $error("monitor off");
endmodule : rsq_reset_checker
bind rsq_reset_sequencer rsq_reset_checker i_chk (.*);

// ===== test/rsq_supply_model.sv
`timescale 1ns/1ps
module rsq_supply_model #(parameter int Ramp = 5) (
	input wire logic clk_sys, // clock
	input wire logic supplyOn, // supply switched on
	input wire logic pinPress, // button on reset pin
	input wire logic resetPinOut, // device pin level
	input wire logic resetPinOe, // device pin drive
	output logic supplyGood, // above threshold
	output logic resetPinIn // resolved wire level
);
	int ramp = 0;
	always @(posedge clk_sys) ramp <= supplyOn ? ramp + 1 : 0;
	// supply sits below threshold for the whole ramp
	assign supplyGood = supplyOn && ramp >= Ramp;
	// pull-up wins unless some party pulls the pin low
	assign resetPinIn = !(pinPress || (resetPinOe && !resetPinOut));
endmodule : rsq_supply_model

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
	import rsq_pkg::*;
	logic clk_sys = 0, rstn = 0, softReset = 0, monitorEnWrite = 0;
	logic monitorEnData = 0, monitorIsSource = 0, supplyOn = 0, pinPress = 0;
	logic supplyGood, resetPinIn, resetPinOut, resetPinOe, cpuHalt, sfrReset;
	logic irqTimerDisable, memWriteBlock, portOpenDrain, weakPullupEn;
	logic wdtEnable, wdtTick, monitorEnable;
	logic [7:0] stackPointerInit, portLatch, reset_cause_register;
	logic [15:0] program_counter;
	logic [1:0] clockSource;
	int failures = 0, total_checks = 0, cyc = 0, n;
	localparam int Rel = 16;
	initial forever #20 clk_sys = !clk_sys;
	rsq_supply_model i_sup (.*);
	rsq_reset_sequencer #(.ReleaseCycles(Rel)) i_dut (.*);
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic waitHalt(logic v);
		n = 0;
		while (cpuHalt !== v && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 200) failures++;
	endtask : waitHalt
	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	task automatic test_power_on();
		@(posedge clk_sys);
		supplyOn <= 1'h1;
		@(negedge clk_sys);
		check("por pin", 16'(resetPinOe), 16'h1);
		waitHalt(1'h0);
		check("delay", 16'(n > Rel), 16'h1);
		check("por flag", 16'(reset_cause_register[1]), 16'h1);
		check("clock src", 16'(clockSource), 16'(ClkSrcInternal));
		check("wdt en", 16'(wdtEnable), 16'h1);
		check("still run", 16'(cpuHalt), 16'h0);
		check("monitor", 16'(monitorEnable), 16'h1);
		check("vector", program_counter, ResetVector);
		check("pullup", 16'(weakPullupEn), 16'h1);
	endtask : test_power_on
	task automatic test_soft();
		@(posedge clk_sys);
		monitorEnWrite <= 1'h1;
		@(posedge clk_sys);
		monitorEnWrite <= 1'h0;
		softReset <= 1'h1;
		@(posedge clk_sys);
		softReset <= 1'h0;
		@(negedge clk_sys);
		check("soft halt", 16'(cpuHalt), 16'h1);
		check("soft pin", 16'(resetPinOe), 16'h0);
		check("mem", 16'(memWriteBlock), 16'h1);
		check("open drain", 16'(portOpenDrain), 16'h1);
		check("latch", 16'(portLatch), 16'(PortLatchReset));
		check("stack", 16'(stackPointerInit), 16'(StackPtrReset));
		waitHalt(1'h0);
		check("soft cause", 16'(reset_cause_register[4:1]), 16'h8);
		check("kept", 16'(monitorEnable), 16'h0);
	endtask : test_soft
	task automatic test_supply();
		@(posedge clk_sys);
		monitorEnWrite <= 1'h1;
		monitorEnData <= 1'h1;
		monitorIsSource <= 1'h1;
		@(posedge clk_sys);
		monitorEnWrite <= 1'h0;
		supplyOn <= 1'h0;
		waitHalt(1'h1);
		check("drop pin", 16'(resetPinOe), 16'h1);
		@(posedge clk_sys);
		supplyOn <= 1'h1;
		waitHalt(1'h0);
		// ramp plus sync only: no power-up delay may be added
		check("no delay", 16'(n < Rel), 16'h1);
		check("drop flag", 16'(reset_cause_register[1]), 16'h1);
	endtask : test_supply
	task automatic test_pin();
		@(posedge clk_sys);
		pinPress <= 1'h1;
		waitHalt(1'h1);
		check("pin only", 16'(resetPinOe), 16'h0);
		@(posedge clk_sys);
		pinPress <= 1'h0;
		waitHalt(1'h0);
		check("pin cause", 16'(reset_cause_register[1:0]), 16'h1);
		while (wdtTick !== 1'h1 && n < 250) @(negedge clk_sys) n++;
		n = 0;
		do @(negedge clk_sys) n++; while (wdtTick !== 1'h1 && n < 40);
		check("wdt", 16'(n), 16'(WdtDivide));
	endtask : test_pin
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		rstn <= 1'h1;
		test_power_on();
		test_soft();
		test_supply();
		test_pin();
		print_verdict();
	end
endmodule : tb
